// [hdl/pcm_perf_counters.sv]
`timescale 1ns/1ps
// Overview of operation
// R1 - registers reached only through index and data
// R2 - index holds register, counter, bank select
// R3 - index bits 17..10 enable/disable cycle counters
// R4 - each counter: config, low value, high value
// R5 - cycle counter counts only while enabled
// R6 - cycle config bit 1 clears counter
// R7 - cycle interrupt filter stops counting in handlers
// R8 - four-bit prescaler divides by two power n
// R9 - cycle overflow flag, write 1 clears
// R10 - cycle config reports counter quantities
// R11 - event select bits 0-3, enable bit 7
// R12 - event config bit 8 clears counter
// R13 - event interrupt filter suppresses counting
// R14 - edge detect counts event start once
// R15 - event overflow flag, write 1 clears
// R16 - tied event counter follows cycle counter
// R17 - cycle filter also filters tied event counters
// R18 - event codes for core event sources
// R19 - codes 10-13 count cycle counter wraps
// R20 - counter widths 18 or 36 at build
// R21 - counter quantities and presence are parameters
// R22 - wrap to zero sets overflow; short high reads 0
// R23 - unused bits read zero, writes ignored
module pcm_perf_counters import pcm_pkg::*; #(
  parameter int pcm_present       = 0,   // block built at all
  parameter int num_cycle_timers  = 2,   // 1..4
  parameter int num_event_tallies = 2,   // 1..16
  parameter int cycle_timer_width = 36,  // 18 or 36
  parameter int event_tally_width = 36   // 18 or 36
) (
  input  wire logic        clk_sys,            // core clock
  input  wire logic        nrst,               // async reset, low
  input  wire logic [3:0]  sfr_num,            // special register number
  input  wire logic        sfr_we,             // write strobe, one cycle
  input  wire logic [17:0] sfr_wdata,          // write data
  input  wire logic        irq_busy,           // core is in an interrupt handler
  input  wire logic        ev_stall,           // pipeline stall
  input  wire logic        ev_data_store,      // data write
  input  wire logic        ev_data_load,       // data read
  input  wire logic        ev_irq_raised,      // interrupt generated
  input  wire logic        ev_nop_done,        // nop executed
  input  wire logic        ev_external_line1,  // pin, asynchronous
  input  wire logic        ev_external_line0,  // pin, asynchronous
  output logic [17:0]      sfr_rdata           // read data, zero when not addressed
);
  // build-time selections
  localparam logic [35:0] CYC_MAX = (cycle_timer_width == HALF_W) ? MAX_18 : MAX_36;  // [R20] [R22]
  localparam logic [35:0] EV_MAX  = (event_tally_width == HALF_W) ? MAX_18 : MAX_36;  // [R20] [R22]
  localparam bit          CYC_LONG = (cycle_timer_width != HALF_W);
  localparam bit          EV_LONG  = (event_tally_width != HALF_W);
  localparam logic [2:0]  NCYC_F   = 3'(num_cycle_timers);
  localparam logic [4:0]  NEV_F    = 5'(num_event_tallies);

  logic [8:0]  idx_reg;        // stored part of the index register
  logic [17:0] sfr_rdata_reg;  // read data flop
  logic [3:0]  idx_regnum;     // selected register number
  logic [3:0]  idx_ctr;        // selected counter
  logic        idx_bank;       // 1 event bank
  logic        wr_idx;         // index register written
  logic        wr_dat;         // data window written
  logic        ext1_s;         // synchronised external line 1
  logic        ext0_s;         // synchronised external line 0
  logic [15:0] ev_bus;         // all event sources by code

  // cross-counter wires, sized to the maximum so selects never overrun
  logic [MAX_CYC-1:0] cyc_run;    // cycle counter enabled
  logic [MAX_CYC-1:0] cyc_iflt;   // cycle interrupt filter
  logic [MAX_CYC-1:0] cyc_clr;    // cycle clear pulse
  logic [MAX_CYC-1:0] cyc_wrap;   // cycle wrap pulse
  logic [17:0]        cyc_cfg_rd [MAX_CYC];  // cycle config readback
  logic [35:0]        cyc_val    [MAX_CYC];  // cycle count
  logic [17:0]        ev_cfg_rd  [MAX_EV];   // event config readback
  logic [35:0]        ev_val     [MAX_EV];   // event count

  assign idx_regnum = idx_reg[IDX_REG_LSB +: 4];  // [R2]
  assign idx_ctr    = idx_reg[IDX_CTR_LSB +: 4];  // [R2]
  assign idx_bank   = idx_reg[IDX_BANK_BIT];      // [R2]
  assign wr_idx     = sfr_we & (sfr_num == SFR_IDX);  // [R1]
  assign wr_dat     = sfr_we & (sfr_num == SFR_DAT);  // [R1]
  assign sfr_rdata  = sfr_rdata_reg;

  // external lines come from pins, so they are synchronised first
  pcm_sync2 u_sync_ext1 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (ev_external_line1),
    .q_out   (ext1_s)
  );

  pcm_sync2 u_sync_ext0 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (ev_external_line0),
    .q_out   (ext0_s)
  );

  // event sources by select code; unlisted codes never fire
  always_comb begin
    ev_bus                             = 16'h0000;
    ev_bus[EV_STALL]                   = ev_stall;           // [R18]
    ev_bus[EV_DATA_STORE]              = ev_data_store;      // [R18]
    ev_bus[EV_DATA_LOAD]               = ev_data_load;       // [R18]
    ev_bus[EV_IRQ_RAISED]              = ev_irq_raised;      // [R18]
    ev_bus[EV_NOP_DONE]                = ev_nop_done;        // [R18]
    ev_bus[EV_EXTERNAL1]               = ext1_s;             // [R18]
    ev_bus[EV_EXTERNAL0]               = ext0_s;             // [R18]
    ev_bus[EV_TIMER0_WRAP +: MAX_CYC]  = cyc_wrap;           // [R19]
  end

  // index register; only bits 8:0 are storage, bits 17:10 are strobes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx_reg <= IDX_RESET;
    end else if (wr_idx) begin
      idx_reg <= sfr_wdata[IDX_KEEP_W-1:0];  // [R2] [R23]
    end
  end

  // cycle counters
  for (genvar c = 0; c < MAX_CYC; c++) begin : g_cyc
    if ((pcm_present != 0) && (c < num_cycle_timers)) begin : g_on  // [R21]
      logic        en_reg;    // counting enabled
      logic        iflt_reg;  // interrupt filter
      logic [3:0]  ps_reg;    // prescaler exponent
      logic        ovf_reg;   // overflow flag
      logic [35:0] cnt_reg;   // count value
      logic        sel;       // this counter is addressed
      logic        cfg_wr;    // config written
      logic        lo_wr;     // low value written
      logic        hi_wr;     // high value written
      logic        run;       // qualified count request
      logic        tick;      // request after prescaling
      logic        wrap;      // top value to zero

      assign sel    = wr_dat & ~idx_bank & (idx_ctr == 4'(c));    // [R1]
      assign cfg_wr = sel & (idx_regnum == REG_CFG);              // [R4]
      assign lo_wr  = sel & (idx_regnum == REG_VAL_LO);           // [R4]
      assign hi_wr  = sel & (idx_regnum == REG_VAL_HI) & CYC_LONG;  // [R4] [R22]
      assign run    = en_reg & ~(iflt_reg & irq_busy);            // [R5] [R7]
      assign wrap   = tick & (cnt_reg == CYC_MAX);                // [R22]

      pcm_prescaler u_ps (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clear    (cyc_clr[c]),
        .tick_in  (run),
        .shift    (ps_reg),
        .tick_out (tick)
      );  // [R8]

      // enable: config bit, or global strobes written through the index
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          en_reg <= 1'b0;
        end else if (wr_idx && sfr_wdata[IDX_GLB_EN0 - 2*c]) begin
          en_reg <= 1'b1;  // [R3]
        end else if (wr_idx && sfr_wdata[IDX_GLB_DIS0 - 2*c]) begin
          en_reg <= 1'b0;  // [R3]
        end else if (cfg_wr) begin
          en_reg <= sfr_wdata[CC_EN_BIT];  // [R5]
        end
      end

      // remaining config fields
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          iflt_reg <= 1'b0;
          ps_reg   <= 4'h0;
        end else if (cfg_wr) begin
          iflt_reg <= sfr_wdata[CC_IFLT_BIT];     // [R7]
          ps_reg   <= sfr_wdata[CC_PS_LSB +: 4];  // [R8]
        end
      end

      // overflow flag; a wrap in the clearing cycle still sets it
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ovf_reg <= 1'b0;
        end else begin
          ovf_reg <= (ovf_reg & ~(cfg_wr & sfr_wdata[CC_OVF_BIT])) | wrap;  // [R9] [R22]
        end
      end

      // count; software writes beat a tick in the same cycle
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cnt_reg <= 36'h000000000;
        end else if (cyc_clr[c]) begin
          cnt_reg <= 36'h000000000;  // [R6]
        end else if (lo_wr) begin
          cnt_reg[HALF_W-1:0] <= sfr_wdata;
        end else if (hi_wr) begin
          cnt_reg[CNT_W-1:HALF_W] <= sfr_wdata;
        end else if (tick) begin
          cnt_reg <= wrap ? 36'h000000000 : 36'(cnt_reg + 36'h000000001);  // [R5] [R22]
        end
      end

      assign cyc_run[c]  = en_reg;
      assign cyc_iflt[c] = iflt_reg;
      assign cyc_clr[c]  = cfg_wr & sfr_wdata[CC_CLR_BIT];  // [R6]
      assign cyc_wrap[c] = wrap;
      assign cyc_val[c]  = cnt_reg;
      // clear bit and bits 3, 17 read as zero
      assign cyc_cfg_rd[c] = {1'b0, NEV_F, NCYC_F, ovf_reg, ps_reg, 1'b0,
                              iflt_reg, 1'b0, en_reg};  // [R10] [R6] [R23]
    end else begin : g_off
      assign cyc_run[c]    = 1'b0;
      assign cyc_iflt[c]   = 1'b0;
      assign cyc_clr[c]    = 1'b0;
      assign cyc_wrap[c]   = 1'b0;
      assign cyc_val[c]    = 36'h000000000;
      assign cyc_cfg_rd[c] = 18'h00000;
    end
  end

  // event counters
  for (genvar e = 0; e < MAX_EV; e++) begin : g_ev
    if ((pcm_present != 0) && (e < num_event_tallies)) begin : g_on  // [R21]
      logic [3:0]  src_reg;   // event select
      logic [1:0]  tsel_reg;  // tied cycle counter
      logic        tie_reg;   // tied mode
      logic        en_reg;    // own enable
      logic        iflt_reg;  // own interrupt filter
      logic        edge_reg;  // edge detect mode
      logic        ovf_reg;   // overflow flag
      logic [3:0]  ps_reg;    // prescaler exponent
      logic        prev_reg;  // selected event last cycle
      logic [35:0] cnt_reg;   // count value
      logic        sel;       // this counter addressed
      logic        cfg_wr;    // config written
      logic        lo_wr;     // low value written
      logic        hi_wr;     // high value written
      logic        clr;       // own or tied clear
      logic        live;      // effective enable
      logic        filt;      // effective interrupt filter
      logic        raw;       // selected event now
      logic        hit;       // event after edge detection
      logic        run;       // qualified count request
      logic        tick;      // request after prescaling
      logic        wrap;      // top value to zero

      assign sel    = wr_dat & idx_bank & (idx_ctr == 4'(e));  // [R1]
      assign cfg_wr = sel & (idx_regnum == REG_CFG);           // [R4]
      assign lo_wr  = sel & (idx_regnum == REG_VAL_LO);        // [R4]
      assign hi_wr  = sel & (idx_regnum == REG_VAL_HI) & EV_LONG;  // [R4] [R22]
      // tied counters take enable and clear from their cycle counter
      assign live   = tie_reg ? cyc_run[tsel_reg] : en_reg;          // [R11] [R16]
      assign clr    = (cfg_wr & sfr_wdata[EC_CLR_BIT]) |
                      (tie_reg & cyc_clr[tsel_reg]);                 // [R12] [R16]
      assign filt   = iflt_reg | (tie_reg & cyc_iflt[tsel_reg]);     // [R13] [R17]
      assign raw    = ev_bus[src_reg];                               // [R11]
      assign hit    = edge_reg ? (raw & ~prev_reg) : raw;            // [R14]
      assign run    = live & hit & ~(filt & irq_busy);               // [R13]
      assign wrap   = tick & (cnt_reg == EV_MAX);                    // [R22]

      pcm_prescaler u_ps (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clear    (clr),
        .tick_in  (run),
        .shift    (ps_reg),
        .tick_out (tick)
      );  // [R8]

      // config fields
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          src_reg  <= 4'h0;
          tsel_reg <= 2'h0;
          tie_reg  <= 1'b0;
          en_reg   <= 1'b0;
          iflt_reg <= 1'b0;
          edge_reg <= 1'b0;
          ps_reg   <= 4'h0;
        end else if (cfg_wr) begin
          src_reg  <= sfr_wdata[EC_SEL_LSB +: 4];   // [R11]
          tsel_reg <= sfr_wdata[EC_TSEL_LSB +: 2];  // [R16]
          tie_reg  <= sfr_wdata[EC_TIE_BIT];        // [R16]
          en_reg   <= sfr_wdata[EC_EN_BIT];         // [R11]
          iflt_reg <= sfr_wdata[EC_IFLT_BIT];       // [R13]
          edge_reg <= sfr_wdata[EC_EDGE_BIT];       // [R14]
          ps_reg   <= sfr_wdata[EC_PS_LSB +: 4];    // [R8]
        end
      end

      // edge history follows the selected source every cycle
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= raw;  // [R14]
        end
      end

      // overflow flag; set wins over the clear
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ovf_reg <= 1'b0;
        end else begin
          ovf_reg <= (ovf_reg & ~(cfg_wr & sfr_wdata[EC_OVF_BIT])) | wrap;  // [R15] [R22]
        end
      end

      // count value
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cnt_reg <= 36'h000000000;
        end else if (clr) begin
          cnt_reg <= 36'h000000000;  // [R12]
        end else if (lo_wr) begin
          cnt_reg[HALF_W-1:0] <= sfr_wdata;
        end else if (hi_wr) begin
          cnt_reg[CNT_W-1:HALF_W] <= sfr_wdata;
        end else if (tick) begin
          cnt_reg <= wrap ? 36'h000000000 : 36'(cnt_reg + 36'h000000001);  // [R22]
        end
      end

      assign ev_val[e]    = cnt_reg;
      // clear bit and bits 16, 17 read as zero
      assign ev_cfg_rd[e] = {2'b00, ps_reg, ovf_reg, edge_reg, iflt_reg, 1'b0,
                             en_reg, tie_reg, tsel_reg, src_reg};  // [R12] [R23]
    end else begin : g_off
      assign ev_val[e]    = 36'h000000000;
      assign ev_cfg_rd[e] = 18'h00000;
    end
  end

  // read data, registered; zero when neither register is addressed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_reg <= 18'h00000;
    end else if (sfr_num == SFR_IDX) begin
      sfr_rdata_reg <= {9'h000, idx_reg};  // [R3] [R23]
    end else if (sfr_num == SFR_DAT) begin
      unique case (idx_regnum)
        REG_CFG: begin
          sfr_rdata_reg <= idx_bank ? ev_cfg_rd[idx_ctr] : cyc_cfg_rd[idx_ctr[1:0]] &
                           {18{idx_ctr < 4'(MAX_CYC)}};  // [R1]
        end
        REG_VAL_LO: begin
          sfr_rdata_reg <= idx_bank ? ev_val[idx_ctr][HALF_W-1:0] :
                           cyc_val[idx_ctr[1:0]][HALF_W-1:0] & {18{idx_ctr < 4'(MAX_CYC)}};
        end
        REG_VAL_HI: begin
          // a short counter's high word is zero by construction
          sfr_rdata_reg <= idx_bank ? ev_val[idx_ctr][CNT_W-1:HALF_W] :
                           cyc_val[idx_ctr[1:0]][CNT_W-1:HALF_W] & {18{idx_ctr < 4'(MAX_CYC)}};  // [R22]
        end
        default: begin
          sfr_rdata_reg <= 18'h00000;  // [R23]
        end
      endcase
    end else begin
      sfr_rdata_reg <= 18'h00000;
    end
  end
endmodule

// [hdl/pcm_pkg.sv]
package pcm_pkg;
  // special function register numbers seen by the core
  localparam logic [3:0] SFR_IDX      = 4'h9;  // index / global enable register
  localparam logic [3:0] SFR_DAT      = 4'hA;  // indirect data window
  // per-counter register numbers
  localparam logic [3:0] REG_CFG      = 4'h0;  // configuration
  localparam logic [3:0] REG_VAL_LO   = 4'h1;  // count bits 17:0
  localparam logic [3:0] REG_VAL_HI   = 4'h2;  // count bits 35:18
  // index register fields
  localparam int IDX_REG_LSB  = 0;   // register number 3:0
  localparam int IDX_CTR_LSB  = 4;   // counter number 7:4
  localparam int IDX_BANK_BIT = 8;   // 1 event bank, 0 cycle bank
  localparam int IDX_KEEP_W   = 9;   // stored bits 8:0
  localparam int IDX_GLB_EN0  = 17;  // enable of cycle counter 0, minus 2 per counter
  localparam int IDX_GLB_DIS0 = 16;  // disable of cycle counter 0, minus 2 per counter
  localparam logic [8:0] IDX_RESET = 9'h000;  // index after reset
  // cycle counter configuration fields
  localparam int CC_EN_BIT    = 0;
  localparam int CC_CLR_BIT   = 1;
  localparam int CC_IFLT_BIT  = 2;
  localparam int CC_PS_LSB    = 4;
  localparam int CC_OVF_BIT   = 8;
  localparam int CC_NCYC_LSB  = 9;
  localparam int CC_NEV_LSB   = 12;
  // event counter configuration fields
  localparam int EC_SEL_LSB   = 0;
  localparam int EC_TSEL_LSB  = 4;
  localparam int EC_TIE_BIT   = 6;
  localparam int EC_EN_BIT    = 7;
  localparam int EC_CLR_BIT   = 8;
  localparam int EC_IFLT_BIT  = 9;
  localparam int EC_EDGE_BIT  = 10;
  localparam int EC_OVF_BIT   = 11;
  localparam int EC_PS_LSB    = 12;
  // event select codes
  localparam int EV_STALL        = 0;
  localparam int EV_DATA_STORE   = 4;
  localparam int EV_DATA_LOAD    = 5;
  localparam int EV_IRQ_RAISED   = 6;
  localparam int EV_NOP_DONE     = 7;
  localparam int EV_EXTERNAL1    = 8;
  localparam int EV_EXTERNAL0    = 9;
  localparam int EV_TIMER0_WRAP  = 10;  // codes 10..13 follow timers 0..3
  // limits of the block
  localparam int MAX_CYC = 4;
  localparam int MAX_EV  = 16;
  localparam int CNT_W   = 36;
  localparam int HALF_W  = 18;
  localparam logic [35:0] MAX_18 = 36'h00003FFFF;  // top value of a short counter
  localparam logic [35:0] MAX_36 = 36'hFFFFFFFFF;  // top value of a long counter
endpackage

// [hdl/pcm_prescaler.sv]
`timescale 1ns/1ps
module pcm_prescaler import pcm_pkg::*; (
  input  wire logic       clk_sys,   // core clock
  input  wire logic       nrst,      // async reset, low
  input  wire logic       clear,     // restart the division
  input  wire logic       tick_in,   // qualified count request
  input  wire logic [3:0] shift,     // divide by two to this power
  output logic            tick_out   // request passed to the counter
);
  logic [14:0] div_reg;  // ticks seen since last pass
  logic [15:0] span;     // 2^shift, 16 bits so 32768 fits
  logic [14:0] limit;    // last count before a pass

  assign span     = 16'h0001 << shift;
  assign limit    = 15'(span - 16'h0001);
  assign tick_out = tick_in & (div_reg == limit);

  // divider; a shift of 0 gives limit 0 so every tick passes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 15'h0000;
    end else if (clear) begin
      div_reg <= 15'h0000;
    end else if (tick_in) begin
      div_reg <= tick_out ? 15'h0000 : 15'(div_reg + 15'h0001);
    end
  end
endmodule

// [hdl/pcm_sync2.sv]
`timescale 1ns/1ps
module pcm_sync2 import pcm_pkg::*; (
  input  wire logic clk_sys,  // core clock
  input  wire logic nrst,     // async reset, low
  input  wire logic d_in,     // level from outside the domain
  output logic      q_out     // synchronised level
);
  logic meta_reg;  // first stage, read only by the second
  logic sync_reg;  // second stage

  // two flops before any logic sees the pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule

// [verification/pcm_core_model.sv]
`timescale 1ns/1ps
module pcm_core_model import pcm_pkg::*; (
  input  wire logic        clk_sys,    // core clock
  output logic [3:0]       sfr_num,    // register number
  output logic             sfr_we,     // write strobe
  output logic [17:0]      sfr_wdata,  // write data
  input  wire logic [17:0] sfr_rdata   // read data
);
  // idle bus until the first access
  initial begin
    sfr_num = 4'h0;
    sfr_we = 1'b0;
    sfr_wdata = 18'h00000;
  end
  // one-cycle strobe; number and data stand with it
  task automatic put(input logic [3:0] n, input logic [17:0] d);
    @(posedge clk_sys);
    sfr_num <= n;
    sfr_we <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_we <= 1'b0;
    sfr_wdata <= ~d;  // stale data must not be reused
  endtask
  // answer registered one edge after the number is shown
  task automatic get(input logic [3:0] n, output logic [17:0] q);
    @(posedge clk_sys);
    sfr_num <= n;
    @(posedge clk_sys);
    #1 q = sfr_rdata;
  endtask
endmodule

// [verification/pcm_perf_counters_properties.sv]
`timescale 1ns/1ps
module pcm_perf_counters_properties import pcm_pkg::*; #(
  parameter int num_cycle_timers  = 2,   // built cycle counters
  parameter int num_event_tallies = 2,   // built event counters
  parameter int event_tally_width = 36   // event counter width
) (
  input  wire logic        clk_sys,    // core clock
  input  wire logic        nrst,       // async reset, low
  input  wire logic [3:0]  sfr_num,    // register number
  input  wire logic        sfr_we,     // write strobe
  input  wire logic [17:0] sfr_wdata,  // write data
  input  wire logic [17:0] sfr_rdata   // read data
);
  logic [8:0] idx_reg;  // shadow of the stored index
  logic [8:0] idx_q;    // index seen by last cycle's read
  logic       dat_q;    // last cycle addressed the data window
  logic       cc_q;     // last read hit a built cycle config
  logic       ec_q;     // last read hit a built event config
  // shadow index, fed by index writes only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) idx_reg <= 9'h000;
    else if (sfr_we && sfr_num == SFR_IDX) idx_reg <= sfr_wdata[8:0];
  end
  // snapshot taken at the edge that registers the read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 9'h000;
      dat_q <= 1'b0;
    end else begin
      idx_q <= idx_reg;
      dat_q <= sfr_num == SFR_DAT;
    end
  end
  assign cc_q = dat_q && !idx_q[8] && idx_q[3:0] == REG_CFG && idx_q[7:4] < num_cycle_timers;
  assign ec_q = dat_q && idx_q[8] && idx_q[3:0] == REG_CFG && idx_q[7:4] < num_event_tallies;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_OFF_ADDR_ZERO: assert property ($past(sfr_num) != SFR_IDX && $past(sfr_num) != SFR_DAT |->
    sfr_rdata == 18'h00000) else $error("read data not zero off address");
  AST_IDX_READBACK: assert property (sfr_we && sfr_num == SFR_IDX ##1 sfr_num == SFR_IDX && !sfr_we |=>
    sfr_rdata[8:0] == $past(sfr_wdata[8:0], 2) && sfr_rdata[17:9] == 9'h000) else $error("index readback wrong");
  AST_CYC_COUNTS: assert property (cc_q |->
    sfr_rdata[16:9] == {5'(num_event_tallies), 3'(num_cycle_timers)}) else $error("counter quantities wrong");
  AST_CYC_CLR_READS0: assert property (cc_q |-> sfr_rdata[1] == 1'b0 && sfr_rdata[3] == 1'b0 &&
    sfr_rdata[17] == 1'b0) else $error("cycle config unused bits set");
  AST_EV_CLR_READS0: assert property (ec_q |-> sfr_rdata[8] == 1'b0 &&
    sfr_rdata[17:16] == 2'b00) else $error("event config unused bits set");
  AST_EV_HI_SHORT: assert property (dat_q && idx_q[8] && idx_q[3:0] == REG_VAL_HI && event_tally_width == 18 |->
    sfr_rdata == 18'h00000) else $error("short counter high word not zero");
  AST_BAD_REG_ZERO: assert property (dat_q && idx_q[3:0] > REG_VAL_HI |->
    sfr_rdata == 18'h00000) else $error("unmapped register not zero");
  AST_BAD_CTR_ZERO: assert property (dat_q && idx_q[7:4] >= (idx_q[8] ? num_event_tallies : num_cycle_timers) |->
    sfr_rdata == 18'h00000) else $error("unbuilt counter not zero");
  cover property (cc_q);
  cover property (ec_q);
  cover property (sfr_we && sfr_num == SFR_DAT);
endmodule
bind pcm_perf_counters pcm_perf_counters_properties #(.num_cycle_timers(num_cycle_timers),
  .num_event_tallies(num_event_tallies), .event_tally_width(event_tally_width)) i_props (.clk_sys(clk_sys),
  .nrst(nrst), .sfr_num(sfr_num), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

// [verification/pcm_perf_counters_tb_top.sv]
`timescale 1ns/1ps
module pcm_perf_counters_tb_top;
  import pcm_pkg::*;
  logic        clk_sys, nrst, sfr_we, irq_busy;  // clock, reset, strobe, handler flag
  logic [3:0]  sfr_num;                          // register number
  logic [17:0] sfr_wdata, sfr_rdata;             // bus data
  logic [6:0]  ev;                               // core event lines, code order
  logic [3:0]  ps;                               // prescaler under test
  int          err_count, checked;               // tallies
  localparam int codes[7] = '{0, 4, 5, 6, 7, 8, 9};  // codes matching ev bits
  pcm_perf_counters #(.pcm_present(1), .num_cycle_timers(2), .num_event_tallies(2),
    .cycle_timer_width(36), .event_tally_width(18)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .sfr_num(sfr_num), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .irq_busy(irq_busy), .ev_stall(ev[0]),
    .ev_data_store(ev[1]), .ev_data_load(ev[2]), .ev_irq_raised(ev[3]), .ev_nop_done(ev[4]),
    .ev_external_line1(ev[5]), .ev_external_line0(ev[6]), .sfr_rdata(sfr_rdata));
  pcm_core_model i_core (.clk_sys(clk_sys), .sfr_num(sfr_num), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  // index first, then the data window
  task automatic wr(input logic [8:0] ix, input logic [17:0] d);
    i_core.put(SFR_IDX, {9'h000, ix});
    i_core.put(SFR_DAT, d);
  endtask
  task automatic rd(input logic [8:0] ix, input logic [17:0] exp);
    logic [17:0] q;
    i_core.put(SFR_IDX, {9'h000, ix});
    i_core.get(SFR_DAT, q);
    chk(q, exp);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    {nrst, irq_busy, ev, err_count, checked} = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(9'h000, 18'h02400);
    rd(9'h100, 18'h00000);
    rd(9'h003, 18'h00000);
    rd(9'h021, 18'h00000);
    $display("test reset values done");
    wr(9'h001, 18'h2A5C3);
    rd(9'h001, 18'h2A5C3);
    wr(9'h002, 18'h15A3C);
    rd(9'h002, 18'h15A3C);
    wr(9'h102, 18'h3FFFF);
    rd(9'h102, 18'h00000);
    $display("test value registers done");
    // 40 requests divide evenly for each prescaler setting 0 to 3
    for (int i = 0; i < 4; i++) begin
      ps = 4'(i);
      wr(9'h000, 18'h00002);
      rd(9'h002, 18'h00000);
      wr(9'h000, {10'h000, ps, 4'h1});
      repeat (36) @(posedge clk_sys);
      wr(9'h000, {10'h000, ps, 4'h0});
      rd(9'h001, 18'h00028 >> ps);
      rd(9'h000, 18'h02400 | {10'h000, ps, 4'h0});
    end
    @(posedge clk_sys) irq_busy <= 1'b1;
    wr(9'h000, 18'h00002);
    wr(9'h000, 18'h00005);
    repeat (36) @(posedge clk_sys);
    wr(9'h000, 18'h00004);
    @(posedge clk_sys) irq_busy <= 1'b0;
    rd(9'h001, 18'h00000);
    $display("test cycle counting done");
    wr(9'h001, 18'h3FFFF);
    wr(9'h002, 18'h3FFFF);
    wr(9'h110, 18'h0014A);
    wr(9'h111, 18'h3FFFF);
    i_core.put(SFR_IDX, 18'h20000);
    i_core.put(SFR_IDX, 18'h10000);
    rd(9'h000, 18'h02504);
    rd(9'h111, 18'h00000);
    rd(9'h110, 18'h0084A);
    wr(9'h000, 18'h00104);
    rd(9'h000, 18'h02404);
    $display("test wrap and global enable done");
    for (int i = 0; i < 7; i++) begin
      wr(9'h100, 18'h00180 | 18'(codes[i]));
      @(posedge clk_sys) ev <= 7'h01 << i;
      repeat (3) @(posedge clk_sys);
      ev <= 7'h00;
      repeat (4) @(posedge clk_sys);
      wr(9'h100, 18'(codes[i]));
      rd(9'h101, 18'h00003);
    end
    wr(9'h100, 18'h00784);
    @(posedge clk_sys) ev <= 7'h02;
    repeat (5) @(posedge clk_sys);
    ev <= 7'h00;
    @(posedge clk_sys) {ev, irq_busy} <= 8'h05;
    @(posedge clk_sys) {ev, irq_busy} <= 8'h00;
    wr(9'h100, 18'h00604);
    rd(9'h101, 18'h00001);
    rd(9'h100, 18'h00604);
    $display("test event counting done");
    test_done();
  end
endmodule
